// File: verilog/sync_slave_pkg.sv
// Constants shared by the synchronous slave serial port and its receive store.
// Assumes a plain register port with a 4-bit word index and 8-bit data.
`default_nettype none

package sync_slave_pkg;

  // ==========================================================================
  // Register word indices
  localparam logic [3:0] TX_STATUS_CONTROL_IDX = 4'h0;
  localparam logic [3:0] RX_STATUS_CONTROL_IDX = 4'h1;
  localparam logic [3:0] BAUD_LINE_CONTROL_IDX = 4'h2;
  localparam logic [3:0] TX_HOLDING_DATA_IDX   = 4'h3;
  localparam logic [3:0] RX_FIFO_DATA_IDX      = 4'h4;
  localparam logic [3:0] IRQ_ENABLE_IDX        = 4'h5;
  localparam logic [3:0] EVENT_FLAGS_IDX       = 4'h6;
  localparam logic [3:0] PIN_REMAP_A_IDX       = 4'h7;
  localparam logic [3:0] PIN_REMAP_B_IDX       = 4'h8;

  // ==========================================================================
  // Field positions, transmit status and control
  localparam int CLOCK_SOURCE_MASTER_BIT = 7;
  localparam int TX_NINE_BIT_SELECT_BIT  = 6;
  localparam int TRANSMIT_ENABLE_BIT     = 5;
  localparam int SYNC_SELECT_BIT         = 4;
  localparam int TX_SHIFT_EMPTY_BIT      = 1;
  localparam int TX_NINTH_BIT_BIT        = 0;
  // Receive status and control
  localparam int SERIAL_PORT_ENABLE_BIT  = 7;
  localparam int RX_NINE_BIT_SELECT_BIT  = 6;
  localparam int SINGLE_RX_ENABLE_BIT    = 5;
  localparam int CONTINUOUS_RX_EN_BIT    = 4;
  localparam int OVERRUN_ERROR_BIT       = 1;
  localparam int RX_NINTH_BIT_BIT        = 0;
  // Baud and line control
  localparam int RX_IDLE_BIT             = 6;
  localparam int CLOCK_POLARITY_BIT      = 4;
  // Interrupt enables
  localparam int TX_IRQ_ENABLE_BIT       = 0;
  localparam int RX_IRQ_ENABLE_BIT       = 1;
  localparam int PERIPHERAL_IRQ_EN_BIT   = 2;
  localparam int GLOBAL_IRQ_ENABLE_BIT   = 3;
  // Event flags
  localparam int TX_BUFFER_EMPTY_BIT     = 0;
  localparam int RX_CHAR_READY_BIT       = 1;
  // Pin remap selects
  localparam int DATA_PIN_SELECT_BIT     = 7;
  localparam int CLOCK_PIN_SELECT_BIT    = 0;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0]  CONTROL_RESET    = 8'h00;
  localparam logic [3:0]  CHAR_BITS_SHORT  = 4'h8;
  localparam logic [3:0]  CHAR_BITS_LONG   = 4'h9;
  localparam int          RX_FIFO_DEPTH    = 2;
  localparam logic [11:0] IRQ_VECTOR_ADDR  = 12'h004;

endpackage : sync_slave_pkg

`default_nettype wire

// File: verilog/rx_char_mem.sv
// Small word store for received characters; read data come from a register.
// Assumes the owner keeps the pointers and never reads an unwritten word.
`default_nettype none

module rx_char_mem
  import sync_slave_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = RX_FIFO_DEPTH,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
)
(
  // Clock and enable
  input  wire logic             clock_i,
  input  wire logic             ce_i,
  // Write port
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // Read port
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ==========================================================================
  // Storage, write through when the head word is written
  always_ff @(posedge clock_i)
  begin
    if (ce_i)
    begin
      if (wr_en_i)
        mem_q[wr_addr_i] <= wr_data_i;
      rd_data_o <= (wr_en_i && wr_addr_i == rd_addr_i) ? wr_data_i : mem_q[rd_addr_i];
    end
  end

endmodule : rx_char_mem

`default_nettype wire

// File: verilog/sync_serial_slave_port.sv
// Synchronous slave serial port: shifts characters on a clock from an outside master.
// Assumes one system clock, a plain register port and pins sampled asynchronously.
//
// How it works
// - A written character moves straight into the shift register and shifts out.
// - A second character waits in holding; the empty flag stays clear.
// - Empty flag with transmit and peripheral enables wakes the core from sleep.
// - Continuous receive enable held set keeps the receiver accepting until an overrun.
// - The single receive enable has no effect on slave reception.
// - Characters arrive during sleep and wake the core with receive enable.
// - Character-ready flag sets on completion; request only with receive enable.
// - Clearing continuous receive or port enable clears overrun; port enable resets the transmit and receive paths.
// - Only synchronous slave mode shifts; other modes stay still, also in sleep.
// - Shift registers advance only on the outside master's clock.
// - A completed word in sleep sets character-ready and, with receive and peripheral enables, wakes the core.
// - After wake the core continues; with global enable it vectors to 004h.
// - When the shift word is out, the held byte loads and empty flag sets.
// - Writing the holding register clears the empty flag.
// - Clock and data pins move to alternate locations by two remap registers.
// - Data change on the leading edge, sampled on trailing; one bit per clock.
// - Receive store holds two; a third sets overrun and stops reception.
// - The clock pin driver stays off in slave operation.
// - Both receive enables clear selects transmit; otherwise transmit stops and the port receives only with continuous enable.
//
// The address map and the address-and-strobe port were decided locally.
`default_nettype none

module sync_serial_slave_port
  import sync_slave_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
)
(
  // Clock, reset, enable
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // Register port
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  // Core power state and wake
  input  wire logic       sleep_i,
  output logic            wake_o,
  output logic            irq_request_o,
  output logic     [11:0] irq_vector_o,
  // Clock pin at its two locations
  input  wire logic [1:0] clock_pin_i,
  output logic      [1:0] clock_pin_o,
  output logic      [1:0] clock_pin_oe_o,
  // Data pin at its two locations
  input  wire logic [1:0] data_pin_i,
  output logic      [1:0] data_pin_o,
  output logic      [1:0] data_pin_oe_o
);

  localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  // Character length from the nine-bit select
  function automatic logic [3:0] char_bits(input logic nine);
    char_bits = nine ? CHAR_BITS_LONG : CHAR_BITS_SHORT;
  endfunction

  // ==========================================================================
  // Control registers
  logic [7:0] tx_ctrl_q;
  logic [7:0] rx_ctrl_q;
  logic [7:0] line_ctrl_q;
  logic [7:0] irq_en_q;
  logic [7:0] remap_a_q;
  logic [7:0] remap_b_q;

  wire wr_tx_ctrl = reg_write_i && reg_addr_i == TX_STATUS_CONTROL_IDX;
  wire wr_rx_ctrl = reg_write_i && reg_addr_i == RX_STATUS_CONTROL_IDX;
  wire wr_line    = reg_write_i && reg_addr_i == BAUD_LINE_CONTROL_IDX;
  wire wr_hold    = reg_write_i && reg_addr_i == TX_HOLDING_DATA_IDX;
  wire wr_irq_en  = reg_write_i && reg_addr_i == IRQ_ENABLE_IDX;
  wire wr_remap_a = reg_write_i && reg_addr_i == PIN_REMAP_A_IDX;
  wire wr_remap_b = reg_write_i && reg_addr_i == PIN_REMAP_B_IDX;
  wire rd_fifo    = reg_read_i && reg_addr_i == RX_FIFO_DATA_IDX;

  wire serial_port_enable    = rx_ctrl_q[SERIAL_PORT_ENABLE_BIT];
  wire continuous_rx_enable  = rx_ctrl_q[CONTINUOUS_RX_EN_BIT];
  wire single_rx_enable      = rx_ctrl_q[SINGLE_RX_ENABLE_BIT];
  wire rx_nine_bit_select    = rx_ctrl_q[RX_NINE_BIT_SELECT_BIT];
  wire clock_source_master   = tx_ctrl_q[CLOCK_SOURCE_MASTER_BIT];
  wire tx_nine_bit_select    = tx_ctrl_q[TX_NINE_BIT_SELECT_BIT];
  wire transmit_enable       = tx_ctrl_q[TRANSMIT_ENABLE_BIT];
  wire tx_ninth_bit          = tx_ctrl_q[TX_NINTH_BIT_BIT];
  wire tx_irq_enable         = irq_en_q[TX_IRQ_ENABLE_BIT];
  wire rx_irq_enable         = irq_en_q[RX_IRQ_ENABLE_BIT];
  wire peripheral_irq_enable = irq_en_q[PERIPHERAL_IRQ_EN_BIT];
  wire global_irq_enable     = irq_en_q[GLOBAL_IRQ_ENABLE_BIT];
  wire data_pin_sel          = remap_a_q[DATA_PIN_SELECT_BIT];
  wire clock_pin_sel         = remap_b_q[CLOCK_PIN_SELECT_BIT];

  // Only synchronous slave mode runs; a disabled port holds the transmit and receive paths in reset
  wire slave_mode = serial_port_enable && tx_ctrl_q[SYNC_SELECT_BIT]
                    && !clock_source_master;
  wire port_clear = !serial_port_enable;
  wire rx_select  = continuous_rx_enable || single_rx_enable;
  wire tx_mode    = slave_mode && !rx_select && transmit_enable;
  wire rx_mode    = slave_mode && rx_select;

  // Register writes
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tx_ctrl_q   <= CONTROL_RESET;
      rx_ctrl_q   <= CONTROL_RESET;
      line_ctrl_q <= CONTROL_RESET;
      irq_en_q    <= CONTROL_RESET;
      remap_a_q   <= CONTROL_RESET;
      remap_b_q   <= CONTROL_RESET;
    end
    else if (ce_i)
    begin
      if (wr_tx_ctrl) tx_ctrl_q   <= reg_wdata_i;
      if (wr_rx_ctrl) rx_ctrl_q   <= reg_wdata_i;
      if (wr_line)    line_ctrl_q <= reg_wdata_i;
      if (wr_irq_en)  irq_en_q    <= reg_wdata_i;
      if (wr_remap_a) remap_a_q   <= reg_wdata_i;
      if (wr_remap_b) remap_b_q   <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // Pin location select and three-stage synchronisers
  wire clock_raw = clock_pin_i[clock_pin_sel];
  wire data_raw  = data_pin_i[data_pin_sel];

  logic [2:0] clk_sync_q;
  logic [2:0] dat_sync_q;
  logic       clk_level_q;
  logic       dat_level_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      clk_sync_q  <= 3'h0;
      dat_sync_q  <= 3'h0;
      clk_level_q <= 1'b0;
      dat_level_q <= 1'b0;
    end
    else if (ce_i)
    begin
      clk_sync_q <= {clk_sync_q[1:0], clock_raw};
      dat_sync_q <= {dat_sync_q[1:0], data_raw};
      if (clk_sync_q[1] == clk_sync_q[2]) clk_level_q <= clk_sync_q[2];
      if (dat_sync_q[1] == dat_sync_q[2]) dat_level_q <= dat_sync_q[2];
    end
  end

  // Edges of the outside clock; polarity picks which one leads
  wire clk_settled   = clk_sync_q[1] == clk_sync_q[2];
  wire clk_rise      = clk_settled && clk_sync_q[2] && !clk_level_q;
  wire clk_fall      = clk_settled && !clk_sync_q[2] && clk_level_q;
  wire clk_invert    = line_ctrl_q[CLOCK_POLARITY_BIT];
  wire leading_edge  = slave_mode && (clk_invert ? clk_fall : clk_rise);
  wire trailing_edge = slave_mode && (clk_invert ? clk_rise : clk_fall);

  // ==========================================================================
  // Transmit path: holding register feeding the shift register
  logic [8:0] tx_holding_reg_q;
  logic       hold_full_q;
  logic [8:0] tx_shift_reg_q;
  logic       shift_full_q;
  logic [3:0] tx_count_q;
  logic       data_out_q;

  wire [3:0] tx_len    = char_bits(tx_nine_bit_select);
  wire       tx_load   = tx_mode && hold_full_q && !shift_full_q;
  wire       tx_step   = shift_full_q && leading_edge && tx_count_q < tx_len;
  wire       tx_done   = shift_full_q && trailing_edge && tx_count_q == tx_len;
  wire       tx_buffer_empty_flag = !hold_full_q;

  // Holding register; a write in the load cycle wins over the emptying
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || port_clear)
    begin
      tx_holding_reg_q <= 9'h000;
      hold_full_q      <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_hold)
        tx_holding_reg_q <= {tx_ninth_bit, reg_wdata_i};
      if (wr_hold)
        hold_full_q <= 1'b1;
      else if (tx_load)
        hold_full_q <= 1'b0;
    end
  end

  // Shift register: out on the leading edge, finished on the trailing edge
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || port_clear)
    begin
      tx_shift_reg_q <= 9'h000;
      shift_full_q   <= 1'b0;
      tx_count_q     <= 4'h0;
      data_out_q     <= 1'b0;
    end
    else if (ce_i)
    begin
      if (tx_load)
      begin
        tx_shift_reg_q <= tx_holding_reg_q;
        shift_full_q   <= 1'b1;
        tx_count_q     <= 4'h0;
      end
      else if (tx_step)
      begin
        data_out_q     <= tx_shift_reg_q[0];
        tx_shift_reg_q <= {1'b0, tx_shift_reg_q[8:1]};
        tx_count_q     <= tx_count_q + 4'h1;
      end
      else if (tx_done || !tx_mode)
      begin
        shift_full_q <= 1'b0;
        tx_count_q   <= 4'h0;
      end
    end
  end

  // ==========================================================================
  // Receive path: shift register into a small character store
  logic [8:0]    rx_shift_reg_q;
  logic [3:0]    rx_count_q;
  logic          overrun_q;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0]   fill_q;
  logic [8:0]    head_char;

  // Reception runs on continuous enable alone; single enable is ignored
  wire       rx_run   = rx_mode && continuous_rx_enable && !overrun_q;
  wire [3:0] rx_len   = char_bits(rx_nine_bit_select);
  wire       rx_bit   = rx_run && trailing_edge;
  wire       rx_last  = rx_bit && rx_count_q == rx_len - 4'h1;
  wire       fifo_pop = rd_fifo && fill_q != '0;
  wire       fifo_full = fill_q == (AW + 1)'(FIFO_DEPTH);
  wire       fifo_push = rx_last && (!fifo_full || fifo_pop);
  wire       overrun_hit = rx_last && fifo_full && !fifo_pop;
  wire [8:0] rx_char  = {rx_nine_bit_select ? dat_level_q : 1'b0,
                         rx_nine_bit_select ? rx_shift_reg_q[8:1]
                                            : {dat_level_q, rx_shift_reg_q[8:2]}};
  wire [AW-1:0] rd_ptr_d = fifo_pop ? rd_ptr_q + AW'(1) : rd_ptr_q;
  wire       rx_char_ready_flag = fill_q != '0;

  // Bits enter at the top and move down, so the first bit ends lowest
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || port_clear)
    begin
      rx_shift_reg_q <= 9'h000;
      rx_count_q     <= 4'h0;
    end
    else if (ce_i)
    begin
      if (!rx_run)
        rx_count_q <= 4'h0;
      else if (rx_last)
        rx_count_q <= 4'h0;
      else if (rx_bit)
      begin
        rx_shift_reg_q <= {dat_level_q, rx_shift_reg_q[8:1]};
        rx_count_q     <= rx_count_q + 4'h1;
      end
    end
  end

  // Store pointers and overrun; clearing continuous enable clears overrun
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || port_clear)
    begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      fill_q    <= '0;
      overrun_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (fifo_push)
        wr_ptr_q <= wr_ptr_q + AW'(1);
      rd_ptr_q <= rd_ptr_d;
      if (fifo_push && !fifo_pop)
        fill_q <= fill_q + (AW + 1)'(1);
      else if (fifo_pop && !fifo_push)
        fill_q <= fill_q - (AW + 1)'(1);
      if (overrun_hit)
        overrun_q <= 1'b1;
      else if (!continuous_rx_enable)
        overrun_q <= 1'b0;
    end
  end

  // Character store; head word kept in a register
  rx_char_mem #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_rx_mem (
    .clock_i   (clock_i),
    .ce_i      (ce_i),
    .wr_en_i   (fifo_push),
    .wr_addr_i (wr_ptr_q),
    .wr_data_i (rx_char),
    .rd_addr_i (rd_ptr_d),
    .rd_data_o (head_char)
  );

  // ==========================================================================
  // Read data selection
  wire [7:0] tx_status = {tx_ctrl_q[7:2], !shift_full_q, tx_ctrl_q[0]};
  wire [7:0] rx_status = {rx_ctrl_q[7:2], overrun_q, head_char[8] && rx_char_ready_flag};
  wire [7:0] line_status = {line_ctrl_q[7], !rx_run, line_ctrl_q[5:0]};
  wire [7:0] flag_status = {6'h00, rx_char_ready_flag, tx_buffer_empty_flag};

  logic [7:0] read_mux;
  always_comb
  begin
    case (reg_addr_i)
      TX_STATUS_CONTROL_IDX: read_mux = tx_status;
      RX_STATUS_CONTROL_IDX: read_mux = rx_status;
      BAUD_LINE_CONTROL_IDX: read_mux = line_status;
      RX_FIFO_DATA_IDX:      read_mux = head_char[7:0];
      IRQ_ENABLE_IDX:        read_mux = irq_en_q;
      EVENT_FLAGS_IDX:       read_mux = flag_status;
      PIN_REMAP_A_IDX:       read_mux = remap_a_q;
      PIN_REMAP_B_IDX:       read_mux = remap_b_q;
      default:               read_mux = 8'h00;
    endcase
  end

  // ==========================================================================
  // Wake and request decoding
  wire tx_event = tx_buffer_empty_flag && tx_irq_enable && tx_mode;
  wire rx_event = rx_char_ready_flag && rx_irq_enable;
  wire any_event = peripheral_irq_enable && (tx_event || rx_event);

  // Registered outputs
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o    <= 8'h00;
      wake_o         <= 1'b0;
      irq_request_o  <= 1'b0;
      irq_vector_o   <= 12'h000;
      clock_pin_o    <= 2'h0;
      clock_pin_oe_o <= 2'h0;
      data_pin_o     <= 2'h0;
      data_pin_oe_o  <= 2'h0;
    end
    else if (ce_i)
    begin
      reg_rdata_o    <= reg_read_i ? read_mux : 8'h00;
      wake_o         <= sleep_i && any_event;
      irq_request_o  <= any_event && global_irq_enable;
      irq_vector_o   <= IRQ_VECTOR_ADDR;
      clock_pin_o    <= 2'h0;
      clock_pin_oe_o <= 2'h0;
      data_pin_o     <= {data_out_q, data_out_q};
      data_pin_oe_o  <= tx_mode ? (data_pin_sel ? 2'h2 : 2'h1) : 2'h0;
    end
  end

endmodule : sync_serial_slave_port

`default_nettype wire

// File: testbench/sync_serial_slave_port_props.sv
// Checker for the slave serial port, seeing only the top module's ports.
// Assumes ce_i high during checks; attached by the bind at the foot.
`default_nettype none
module sync_serial_slave_port_props
  import sync_slave_pkg::*;
(
  // Clock, reset, enable
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        ce_i,
  // Register port
  input wire logic [3:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_write_i,
  input wire logic        reg_read_i,
  input wire logic [7:0]  reg_rdata_o,
  // Power state and wake
  input wire logic        sleep_i,
  input wire logic        wake_o,
  input wire logic        irq_request_o,
  input wire logic [11:0] irq_vector_o,
  // Pins
  input wire logic [1:0]  clock_pin_i,
  input wire logic [1:0]  clock_pin_o,
  input wire logic [1:0]  clock_pin_oe_o,
  input wire logic [1:0]  data_pin_i,
  input wire logic [1:0]  data_pin_o,
  input wire logic [1:0]  data_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_ctrl_q, rx_ctrl_q, irq_en_q, remap_a_q;
  // ==========================================================================
  // Shadow copies of the control words
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      tx_ctrl_q <= 8'h00;
      rx_ctrl_q <= 8'h00;
      irq_en_q  <= 8'h00;
      remap_a_q <= 8'h00;
    end
    else if (reg_write_i && ce_i)
    begin
      if (reg_addr_i == TX_STATUS_CONTROL_IDX) tx_ctrl_q <= reg_wdata_i;
      if (reg_addr_i == RX_STATUS_CONTROL_IDX) rx_ctrl_q <= reg_wdata_i;
      if (reg_addr_i == IRQ_ENABLE_IDX) irq_en_q <= reg_wdata_i;
      if (reg_addr_i == PIN_REMAP_A_IDX) remap_a_q <= reg_wdata_i;
    end
  end
  // Slave transmit mode as software set it
  wire tx_mode = tx_ctrl_q[SYNC_SELECT_BIT] & tx_ctrl_q[TRANSMIT_ENABLE_BIT]
                 & ~tx_ctrl_q[CLOCK_SOURCE_MASTER_BIT] & rx_ctrl_q[SERIAL_PORT_ENABLE_BIT]
                 & (rx_ctrl_q[5:4] == 2'b00);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  clk_pin_off_a: assert property (clock_pin_oe_o == 2'b00 && clock_pin_o == 2'b00)
    else $error("clock pin driven in slave mode");
  tx_oe_mode_a: assert property (data_pin_oe_o != 2'b00 |-> $past(tx_mode) || $past(tx_mode, 2))
    else $error("data pin driven outside transmit mode");
  rx_oe_off_a: assert property (rx_ctrl_q[CONTINUOUS_RX_EN_BIT] [*3] |-> data_pin_oe_o == 2'b00)
    else $error("data pin driven while receiving");
  oe_location_a: assert property (data_pin_oe_o != 2'b00 |->
    data_pin_oe_o == ($past(remap_a_q[DATA_PIN_SELECT_BIT]) ? 2'b10 : 2'b01))
    else $error("data pin driven at wrong location");
  data_pair_a: assert property (data_pin_o[0] == data_pin_o[1])
    else $error("data pin locations disagree");
  wake_cause_a: assert property (wake_o |->
    $past(sleep_i) && $past(irq_en_q[PERIPHERAL_IRQ_EN_BIT]))
    else $error("wake without sleep or peripheral enable");
  irq_cause_a: assert property (irq_request_o |-> $past(irq_en_q[GLOBAL_IRQ_ENABLE_BIT]))
    else $error("request without global enable");
  irq_vector_a: assert property ($past(rst_n_i) |-> irq_vector_o == IRQ_VECTOR_ADDR)
    else $error("wrong handler address");
  read_idle_a: assert property (!$past(reg_read_i) || $past(reg_addr_i) > PIN_REMAP_B_IDX
    |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  hold_write_a: assert property (reg_write_i && reg_addr_i == TX_HOLDING_DATA_IDX
    && !irq_en_q[RX_IRQ_ENABLE_BIT] |-> ##[2:3] !wake_o)
    else $error("wake stays after holding write");
  // Main scenarios reached
  cover property (wake_o);
  cover property (irq_request_o);
  cover property (data_pin_oe_o != 2'b00);
  cover property ($past(reg_read_i) && reg_rdata_o != 8'h00);
endmodule // sync_serial_slave_port_props
bind sync_serial_slave_port sync_serial_slave_port_props chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .sleep_i(sleep_i), .wake_o(wake_o),
  .irq_request_o(irq_request_o), .irq_vector_o(irq_vector_o), .clock_pin_i(clock_pin_i),
  .clock_pin_o(clock_pin_o), .clock_pin_oe_o(clock_pin_oe_o), .data_pin_i(data_pin_i),
  .data_pin_o(data_pin_o), .data_pin_oe_o(data_pin_oe_o));
`default_nettype wire

// File: testbench/sync_master_model.sv
// Outside synchronous master: makes the link clock and drives or reads data.
// Assumes clock polarity clear, so the rising edge leads; 48 ns per bit.
`default_nettype none
module sync_master_model
(
  // Pins towards the port, digital levels only
  output var logic  [1:0] clock_pin_o,
  output var logic  [1:0] data_pin_o,
  input  wire logic [1:0] data_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock idles low between frames
  initial
  begin
    clock_pin_o = 2'b00;
    data_pin_o  = 2'b01;
  end
  // One frame of n bits at location loc, least significant bit first
  task automatic xfer(input logic [8:0] tx, input int n, input int loc,
                      output logic [8:0] rx);
    rx = 9'h000;
    #1;
    for (int i = 0; i < n; i++)
    begin
      clock_pin_o[loc] = 1'b1;
      data_pin_o[loc]  = tx[i];
      #24;
      clock_pin_o[loc] = 1'b0;
      rx[i] = data_pin_i[loc];
      #24;
    end
    // Released line shows the inverse, not the last bit
    data_pin_o = ~data_pin_o;
  endtask
endmodule // sync_master_model
`default_nettype wire

// File: testbench/sync_serial_slave_port_tb_top.sv
// Self-checking bench for the slave serial port with an outside master model.
// Assumes the checker is bound in; all register traffic goes through wr and rd.
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module sync_serial_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sync_slave_pkg::*;
  logic clock_i, rst_n_i, reg_write_i, reg_read_i, sleep_i, wake_o, irq_request_o;
  logic [3:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i, reg_rdata_o;
  logic [11:0] irq_vector_o;
  logic [1:0]  dev_clk, dev_clk_oe, dev_dat, dev_dat_oe, m_clk, m_dat;
  wire  [1:0]  clk_wire = (dev_clk_oe & dev_clk) | (~dev_clk_oe & m_clk);
  wire  [1:0]  dat_wire = (dev_dat_oe & dev_dat) | (~dev_dat_oe & m_dat);
  logic [8:0]  got;
  int n_errors = 0, comparisons = 0;
  sync_serial_slave_port uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .sleep_i(sleep_i), .wake_o(wake_o),
    .irq_request_o(irq_request_o), .irq_vector_o(irq_vector_o), .clock_pin_i(clk_wire),
    .clock_pin_o(dev_clk), .clock_pin_oe_o(dev_clk_oe), .data_pin_i(dat_wire),
    .data_pin_o(dev_dat), .data_pin_oe_o(dev_dat_oe));
  sync_master_model master (.clock_pin_o(m_clk), .data_pin_o(m_dat), .data_pin_i(dat_wire));
  // ==========================================================================
  // Clock, 4 ns period
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Read with masked compare; data stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                    input string nm);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1;
    `CHK(nm, e, reg_rdata_o & m)
    @(posedge clock_i);
  endtask
  task automatic settle();
    repeat (8) @(posedge clock_i);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_n_i, reg_write_i, reg_read_i, sleep_i} = 4'h0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(TX_STATUS_CONTROL_IDX, 8'hfd, CONTROL_RESET, "tx ctrl reset");
    rd(RX_STATUS_CONTROL_IDX, 8'hff, CONTROL_RESET, "rx ctrl reset");
    rd(4'hf, 8'hff, 8'h00, "unmapped");
    // Transmit: two characters queued, then sleep
    wr(RX_STATUS_CONTROL_IDX, 8'h80);
    wr(TX_STATUS_CONTROL_IDX, 8'h30);
    wr(IRQ_ENABLE_IDX, 8'h05);
    wr(TX_HOLDING_DATA_IDX, 8'ha5);
    wr(TX_HOLDING_DATA_IDX, 8'h3c);
    settle();
    rd(EVENT_FLAGS_IDX, 8'h01, 8'h00, "tx empty held");
    `CHK("data oe", 2'b01, dev_dat_oe)
    `CHK("clock oe", 2'b00, dev_clk_oe)
    sleep_i <= 1'b1;
    master.xfer(9'h000, 8, 0, got);
    settle();
    `CHK("tx first", 9'h0a5, got)
    rd(EVENT_FLAGS_IDX, 8'h01, 8'h01, "tx empty set");
    `CHK("wake tx", 1'b1, wake_o)
    `CHK("irq no global", 1'b0, irq_request_o)
    wr(IRQ_ENABLE_IDX, 8'h0d);
    settle();
    `CHK("irq global", 1'b1, irq_request_o)
    `CHK("vector", 12'h004, irq_vector_o)
    wr(TX_HOLDING_DATA_IDX, 8'h77);
    settle();
    rd(EVENT_FLAGS_IDX, 8'h01, 8'h00, "tx empty clear");
    `CHK("wake cleared", 1'b0, wake_o)
    master.xfer(9'h000, 8, 0, got);
    `CHK("tx second", 9'h03c, got)
    master.xfer(9'h000, 8, 0, got);
    `CHK("tx third", 9'h077, got)
    sleep_i <= 1'b0;
    // Nine-bit transmit
    wr(TX_STATUS_CONTROL_IDX, 8'h71);
    wr(TX_HOLDING_DATA_IDX, 8'h5a);
    settle();
    master.xfer(9'h000, 9, 0, got);
    `CHK("tx nine", 9'h15a, got)
    // Not in sync mode: no driving
    wr(TX_STATUS_CONTROL_IDX, 8'h20);
    settle();
    `CHK("oe async", 2'b00, dev_dat_oe)
    // Receive at alternate pins, single enable also set
    wr(RX_STATUS_CONTROL_IDX, 8'h00);
    wr(PIN_REMAP_A_IDX, 8'h80);
    wr(PIN_REMAP_B_IDX, 8'h01);
    wr(TX_STATUS_CONTROL_IDX, 8'h10);
    wr(IRQ_ENABLE_IDX, 8'h0e);
    wr(RX_STATUS_CONTROL_IDX, 8'hb0);
    settle();
    `CHK("rx oe", 2'b00, dev_dat_oe)
    rd(BAUD_LINE_CONTROL_IDX, 8'h40, 8'h00, "rx idle");
    rd(EVENT_FLAGS_IDX, 8'h02, 8'h00, "rx store empty");
    sleep_i <= 1'b1;
    master.xfer(9'h081, 8, 1, got);
    settle();
    rd(EVENT_FLAGS_IDX, 8'h02, 8'h02, "char ready");
    `CHK("wake rx", 1'b1, wake_o)
    `CHK("irq rx", 1'b1, irq_request_o)
    master.xfer(9'h042, 8, 1, got);
    master.xfer(9'h099, 8, 1, got);
    settle();
    rd(RX_STATUS_CONTROL_IDX, 8'h02, 8'h02, "overrun");
    rd(RX_FIFO_DATA_IDX, 8'hff, 8'h81, "rx first");
    rd(RX_FIFO_DATA_IDX, 8'hff, 8'h42, "rx second");
    rd(EVENT_FLAGS_IDX, 8'h02, 8'h00, "ready clear");
    sleep_i <= 1'b0;
    wr(RX_STATUS_CONTROL_IDX, 8'h80);
    settle();
    rd(RX_STATUS_CONTROL_IDX, 8'h02, 8'h00, "overrun clear");
    // Nine-bit receive
    wr(RX_STATUS_CONTROL_IDX, 8'hd0);
    master.xfer(9'h1c3, 9, 1, got);
    settle();
    rd(RX_STATUS_CONTROL_IDX, 8'h01, 8'h01, "rx ninth");
    rd(RX_FIFO_DATA_IDX, 8'hff, 8'hc3, "rx nine low");
    wrap_up();
  end
endmodule // sync_serial_slave_port_tb_top
`default_nettype wire
